// file: hdl/ltmc_params.svh
// Offsets, reset values, field positions and timing counts for the
// transceiver mode controller. Included by the top, the wake filter and the bench.
`ifndef LTMC_PARAMS_SVH
`define LTMC_PARAMS_SVH
`define LTMC_IDX_CTRL        8'h21
`define LTMC_IDX_STAT        8'h24
`define LTMC_IDX_WAKE        8'h28
`define LTMC_IDX_DEV         8'h29
`define LTMC_CTRL_RST        8'h01
`define LTMC_STAT_RST        8'h00
`define LTMC_WAKE_RST        8'h00
`define LTMC_DEV_RST         8'h00
`define LTMC_SEL_STANDBY     2'b01
`define LTMC_SEL_NORMAL      2'b10
`define LTMC_BIT_READY       0
`define LTMC_BIT_TXTO        1
`define LTMC_BIT_WAKE_EN     0
`define LTMC_BIT_WAKE_ST     1
`define LTMC_CLK_MHZ         100
`define LTMC_WAKE_FILT_US    100
`define LTMC_WAKE_FILT_CYC   (`LTMC_WAKE_FILT_US * `LTMC_CLK_MHZ)
`endif

// file: hdl/ltmc_pkg.sv
// Types shared by the transceiver mode controller files.
// Assumes the params header sits in the include path.
package ltmc_pkg;
	typedef enum logic [1:0] {
		LTMC_UNPOWERED = 2'b00,
		LTMC_STANDBY   = 2'b01,
		LTMC_NORMAL    = 2'b11
	} ltmc_state_t;

	typedef enum logic [2:0] {
		LTMC_DEV_OFF     = 3'h0,
		LTMC_DEV_UCRESET = 3'h1,
		LTMC_DEV_SLEEP   = 3'h2,
		LTMC_DEV_STANDBY = 3'h3,
		LTMC_DEV_NORMAL  = 3'h4
	} ltmc_devmode_t;

	typedef struct packed {
		logic vs_pwron;
		logic vs_pwroff;
		logic vs_uv;
		logic vcc_uv;
		logic overtemp;
	} ltmc_supply_t;

	typedef struct packed {
		logic strong_pullup;
		logic termination_on;
		logic tx_enable;
		logic wake_rx_on;
	} ltmc_phy_t;
endpackage

// file: hdl/ltmc_top.sv
// Transceiver mode controller with AXI4-Lite register slave.
// Assumes all status inputs are synchronous to core_clk.
//
// Contract
// - No wake detection in Normal state
// - Normal only with all conditions and code
// - Power-up leads automatically to Standby
// - Standby disables bus and termination
// - Prewake level enables pullup, receiver, timer
// - Valid wake sets wake status bit
// - Wake signalled on both receive outputs
// - Pullup off only in Standby, status cleared
// - Overtemperature disables wake detection
// - Normal falls to Standby on any fault
// - Power-on threshold, undervoltage clear gating
// - Power-off threshold in Standby gives Unpowered
// - Wake accepted only above undervoltage level
// - Control at 0x21, reset 0x01, reserved bits
// - Mode field is target, never modified
// - Status bit1 shows transmit timeout
// - Status bit0 shows transceiver ready
// - Wake needs long dominant then rising edge
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
`include "ltmc_params.svh"
module ltmc_top #(
	parameter int unsigned WAKE_FILT_CYC = `LTMC_WAKE_FILT_CYC
) (
	input  wire logic                  core_clk,
	input  wire logic                  rst,
	input  wire logic [31:0]           s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	input  wire logic [31:0]           s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	output logic [31:0]                s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	input  wire ltmc_pkg::ltmc_supply_t supply,
	input  wire logic                  tx_timeout,
	input  wire logic                  bus_below_prewake,
	input  wire logic                  bus_level,
	input  wire logic                  lin_rx_in,
	output ltmc_pkg::ltmc_phy_t        phy,
	output logic                       can_rx_out,
	output logic                       lin_rx_out,
	output ltmc_pkg::ltmc_state_t      trx_state
);
	////////////////////////////////////////////////////////////////////////
	// Registers
	ltmc_pkg::ltmc_state_t st_q, st_d;
	logic [1:0]  sel_q;
	logic        wake_en_q;
	logic        wake_st_q;
	logic [2:0]  dev_q;
	logic        pullup_q;
	logic        wake_ind_q;
	logic [7:0]  rbyte;
	logic        aw_got_q, w_got_q;
	logic [31:0] aw_addr_q, w_data_q;
	logic [3:0]  w_strb_q;
	logic        bvalid_q, bresp_err_q;
	logic        rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0]  rresp_q;

	////////////////////////////////////////////////////////////////////////
	// AXI write path: address and data latched independently
	assign s_axi_awready = ~aw_got_q & ~bvalid_q;
	assign s_axi_wready  = ~w_got_q & ~bvalid_q;
	wire         wr_go   = aw_got_q & w_got_q & ~bvalid_q;
	wire [7:0]   wr_idx  = aw_addr_q[9:2];
	wire         wr_lane = w_strb_q[0];
	wire         wr_ctrl = wr_go & (wr_idx == `LTMC_IDX_CTRL);
	wire         wr_stat = wr_go & (wr_idx == `LTMC_IDX_STAT);
	wire         wr_wake = wr_go & (wr_idx == `LTMC_IDX_WAKE);
	wire         wr_dev  = wr_go & (wr_idx == `LTMC_IDX_DEV);
	wire         wr_hit  = wr_ctrl | wr_stat | wr_wake | wr_dev;
	wire         wr_addr_ok = (aw_addr_q[31:10] == 22'h0);

	always_ff @(posedge core_clk) begin
		if (rst) begin
			aw_got_q  <= 1'b0;
			w_got_q   <= 1'b0;
			aw_addr_q <= 32'h00000000;
			w_data_q  <= 32'h00000000;
			w_strb_q  <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got_q  <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end else if (wr_go)
				aw_got_q <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) begin
				w_got_q  <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end else if (wr_go)
				w_got_q <= 1'b0;
		end
	end

	// Write response; unmapped addresses answer SLVERR
	always_ff @(posedge core_clk) begin
		if (rst) begin
			bvalid_q    <= 1'b0;
			bresp_err_q <= 1'b0;
		end else if (wr_go) begin
			bvalid_q    <= 1'b1;
			bresp_err_q <= ~(wr_hit & wr_addr_ok);
		end else if (s_axi_bready)
			bvalid_q <= 1'b0;
	end
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp  = bresp_err_q ? 2'b10 : 2'b00;

	////////////////////////////////////////////////////////////////////////
	// Software-held fields; the state machine never writes sel_q
	wire         wr_ok = wr_lane & wr_addr_ok;
	always_ff @(posedge core_clk) begin
		if (rst) begin
			sel_q     <= 2'(`LTMC_CTRL_RST);
			wake_en_q <= 1'b0;
			dev_q     <= 3'h0;
		end else begin
			if (wr_ctrl && wr_ok)
				sel_q <= w_data_q[1:0];
			if (wr_wake && wr_ok)
				wake_en_q <= w_data_q[`LTMC_BIT_WAKE_EN];
			if (wr_dev && wr_ok)
				dev_q <= w_data_q[2:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Transceiver state machine
	wire dev_normal = (dev_q == ltmc_pkg::LTMC_DEV_NORMAL);
	wire sel_normal = (sel_q == `LTMC_SEL_NORMAL);
	wire go_normal  = dev_normal & ~supply.vcc_uv & ~supply.vs_uv
		& ~supply.overtemp & sel_normal;

	always_comb begin
		st_d = st_q;
		unique case (st_q)
			ltmc_pkg::LTMC_UNPOWERED:
				if (supply.vs_pwron)
					st_d = ltmc_pkg::LTMC_STANDBY;
			ltmc_pkg::LTMC_STANDBY:
				if (supply.vs_pwroff)
					st_d = ltmc_pkg::LTMC_UNPOWERED;
				else if (go_normal)
					st_d = ltmc_pkg::LTMC_NORMAL;
			ltmc_pkg::LTMC_NORMAL:
				if (!go_normal)
					st_d = ltmc_pkg::LTMC_STANDBY;
			default:
				st_d = ltmc_pkg::LTMC_UNPOWERED;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (rst)
			st_q <= ltmc_pkg::LTMC_UNPOWERED;
		else
			st_q <= st_d;
	end
	assign trx_state = st_q;

	////////////////////////////////////////////////////////////////////////
	// Wake path: armed only in Standby, not hot, supply above undervoltage
	wire in_standby = (st_q == ltmc_pkg::LTMC_STANDBY);
	wire wake_arm   = in_standby & wake_en_q & ~supply.overtemp
		& ~supply.vs_uv;
	wire prewake    = wake_arm & bus_below_prewake;
	wire wake_pulse;

	ltmc_wake_filter #(
		.FILT_CYC (WAKE_FILT_CYC)
	) u_filt (
		.core_clk   (core_clk),
		.rst        (rst),
		.arm        (prewake | (wake_arm & pullup_q)),
		.bus_level  (bus_level),
		.wake_pulse (wake_pulse)
	);

	// Status set wins over a clear written in the same cycle
	wire wake_clr = wr_wake & wr_ok & ~w_data_q[`LTMC_BIT_WAKE_ST];
	always_ff @(posedge core_clk) begin
		if (rst)
			wake_st_q <= 1'b0;
		else if (wake_pulse)
			wake_st_q <= 1'b1;
		else if (wake_clr)
			wake_st_q <= 1'b0;
	end

	// Strong pull-up stays until Standby with status cleared
	always_ff @(posedge core_clk) begin
		if (rst)
			pullup_q <= 1'b0;
		else if (prewake || wake_pulse)
			pullup_q <= 1'b1;
		else if (in_standby && !wake_st_q)
			pullup_q <= 1'b0;
	end

	// Wake indication held on receive outputs while status is set outside Normal
	always_ff @(posedge core_clk) begin
		if (rst)
			wake_ind_q <= 1'b0;
		else
			wake_ind_q <= wake_st_q & ~(st_q == ltmc_pkg::LTMC_NORMAL);
	end

	wire is_normal = (st_q == ltmc_pkg::LTMC_NORMAL);
	assign phy.strong_pullup  = pullup_q;
	assign phy.termination_on = is_normal;
	assign phy.tx_enable      = is_normal & ~tx_timeout;
	assign phy.wake_rx_on     = prewake | (wake_arm & pullup_q);
	// Low level on receive pins flags a wake to the host
	assign lin_rx_out = is_normal ? lin_rx_in : ~wake_ind_q;
	assign can_rx_out = ~wake_ind_q;

	////////////////////////////////////////////////////////////////////////
	// Read path, one cycle after address accepted
	wire [7:0] rd_idx  = s_axi_araddr[9:2];
	wire       rd_ok   = (s_axi_araddr[31:10] == 22'h0);
	wire [7:0] stat_b  = {6'h00, tx_timeout, is_normal & ~tx_timeout};
	always_comb begin
		rbyte = 8'h00;
		unique case (rd_idx)
			`LTMC_IDX_CTRL: rbyte = {6'h00, sel_q};
			`LTMC_IDX_STAT: rbyte = stat_b;
			`LTMC_IDX_WAKE: rbyte = {6'h00, wake_st_q, wake_en_q};
			`LTMC_IDX_DEV:  rbyte = {5'h00, dev_q};
			default:        rbyte = 8'h00;
		endcase
	end
	wire rd_hit = rd_ok & ((rd_idx == `LTMC_IDX_CTRL)
		| (rd_idx == `LTMC_IDX_STAT) | (rd_idx == `LTMC_IDX_WAKE)
		| (rd_idx == `LTMC_IDX_DEV));

	assign s_axi_arready = ~rvalid_q;
	always_ff @(posedge core_clk) begin
		if (rst) begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h00000000;
			rresp_q  <= 2'b00;
		end else if (s_axi_arvalid && !rvalid_q) begin
			rvalid_q <= 1'b1;
			// Rejected addresses return zero so no field leaks out
			rdata_q  <= rd_hit ? {24'h000000, rbyte} : 32'h00000000;
			rresp_q  <= rd_hit ? 2'b00 : 2'b10;
		end else if (s_axi_rready)
			rvalid_q <= 1'b0;
	end
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata  = rdata_q;
	assign s_axi_rresp  = rresp_q;
endmodule

// file: hdl/ltmc_wake_filter.sv
// Bus wake filter: dominant longer than the filter time, then recessive.
// Assumes bus level is synchronous to core_clk; 1 means recessive.
`timescale 1ns/1ps
`include "ltmc_params.svh"
module ltmc_wake_filter #(
	parameter int unsigned FILT_CYC = `LTMC_WAKE_FILT_CYC
) (
	input  wire logic core_clk,
	input  wire logic rst,
	input  wire logic arm,
	input  wire logic bus_level,
	output logic      wake_pulse
);
	logic [23:0] cnt_q;
	logic        long_q;
	logic        bus_q;
	wire         rise     = bus_level & ~bus_q;
	wire         expired  = (cnt_q >= 24'(FILT_CYC));

	// Counter restarts whenever the bus turns recessive before expiry
	always_ff @(posedge core_clk) begin
		if (rst || !arm) begin
			cnt_q  <= 24'h000000;
			long_q <= 1'b0;
			bus_q  <= 1'b1;
		end else begin
			bus_q <= bus_level;
			if (bus_level)
				cnt_q <= 24'h000000;
			else if (!expired)
				cnt_q <= cnt_q + 24'h000001;
			if (!bus_level && expired)
				long_q <= 1'b1;
			else if (bus_level)
				long_q <= 1'b0;
		end
	end

	assign wake_pulse = arm & rise & long_q;
endmodule

// file: tb/ltmc_bus_model.sv
// LIN bus node model driving the bus level seen by the controller.
// Assumes the bench calls pulse_dom from its main thread.
`timescale 1ns/1ps
module ltmc_bus_model (
	input  wire logic core_clk,
	output logic      bus_level,
	output logic      bus_below_prewake,
	output logic      lin_rx_in
);
	// Idle bus sits recessive through the pull-up
	initial bus_level = 1'b1;
	// Dominant level is always under the prewake threshold
	assign bus_below_prewake = !bus_level;
	assign lin_rx_in         = bus_level;
	// Hold a level from the next edge on, for checks while it stands
	task automatic set_level(input logic v);
		@(posedge core_clk);
		bus_level <= v;
	endtask
	// Dominant for n cycles, then the rising edge a wake needs
	task automatic pulse_dom(input int n);
		@(posedge core_clk);
		bus_level <= 1'b0;
		repeat (n) @(posedge core_clk);
		bus_level <= 1'b1;
		repeat (6) @(posedge core_clk);
	endtask
endmodule

// file: tb/ltmc_chk.sv
// Checker for the mode controller, bound to the top module ports.
// Assumes one clock domain with a synchronous reset.
`timescale 1ns/1ps
module ltmc_chk (
	input wire logic                   core_clk,
	input wire logic                   rst,
	input wire ltmc_pkg::ltmc_supply_t supply,
	input wire logic                   bus_below_prewake,
	input wire ltmc_pkg::ltmc_phy_t    phy,
	input wire ltmc_pkg::ltmc_state_t  trx_state
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	// State decodes shared by the properties
	wire stby = trx_state == ltmc_pkg::LTMC_STANDBY;
	wire norm = trx_state == ltmc_pkg::LTMC_NORMAL;
	wire unp  = trx_state == ltmc_pkg::LTMC_UNPOWERED;
	sequence fault_s;
		supply.vcc_uv || supply.vs_uv || supply.overtemp;
	endsequence
	//////////////////////////////////////////////////////////////
	no_wake_norm_a: assert property (norm |-> !phy.wake_rx_on)
		else $error("wake path active in normal");
	norm_entry_a: assert property ($rose(norm) |->
		$past(stby && !supply.vcc_uv && !supply.vs_uv && !supply.overtemp))
		else $error("normal entered without clean supply");
	fault_drop_a: assert property (norm ##0 fault_s |=> stby)
		else $error("fault did not force standby");
	power_up_a: assert property (unp && supply.vs_pwron |=> stby)
		else $error("no standby after power on");
	power_off_a: assert property (stby && supply.vs_pwroff |=> unp)
		else $error("no unpowered after power off");
	standby_quiet_a: assert property (!norm |->
		!phy.tx_enable && !phy.termination_on)
		else $error("bus driven outside normal");
	otp_wake_off_a: assert property (supply.overtemp |-> !phy.wake_rx_on)
		else $error("wake path active in overtemperature");
	pullup_cause_a: assert property ($rose(phy.strong_pullup) |->
		$past(stby && bus_below_prewake && !supply.overtemp && !supply.vs_uv))
		else $error("strong pull-up without prewake cause");
endmodule

// file: tb/ltmc_top_tb.sv
// Self-checking bench for the transceiver mode controller.
// Assumes design files, bus model and checker compile first.
`timescale 1ns/1ps
`include "ltmc_params.svh"
module ltmc_top_tb;
	localparam logic [31:0] CTRL = 4 * `LTMC_IDX_CTRL;
	localparam logic [31:0] STAT = 4 * `LTMC_IDX_STAT;
	localparam logic [31:0] WAKE = 4 * `LTMC_IDX_WAKE;
	localparam logic [31:0] DEVM = 4 * `LTMC_IDX_DEV;
	logic                   core_clk, rst, awv, wv, bre, arv, rre, tx_to;
	logic [31:0]            awa, wd, ara, r_dat;
	logic                   aw_rdy, w_rdy, b_vld, ar_rdy, r_vld;
	logic [1:0]             b_rsp, r_rsp, last_rsp, last_bresp;
	logic [3:0]             strb;
	logic                   can_rx, lin_rx, bl, bp, lri;
	ltmc_pkg::ltmc_supply_t sup;
	ltmc_pkg::ltmc_phy_t    phy;
	ltmc_pkg::ltmc_state_t  st;
	int                     bad_count = 0, compares = 0, cyc = 0;
	ltmc_top #(.WAKE_FILT_CYC(8)) dut (.core_clk(core_clk), .rst(rst),
		.s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(aw_rdy),
		.s_axi_wdata(wd), .s_axi_wstrb(strb), .s_axi_wvalid(wv),
		.s_axi_wready(w_rdy), .s_axi_bresp(b_rsp), .s_axi_bvalid(b_vld),
		.s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv),
		.s_axi_arready(ar_rdy), .s_axi_rdata(r_dat), .s_axi_rresp(r_rsp),
		.s_axi_rvalid(r_vld), .s_axi_rready(rre), .supply(sup),
		.tx_timeout(tx_to), .bus_below_prewake(bp), .bus_level(bl),
		.lin_rx_in(lri), .phy(phy), .can_rx_out(can_rx),
		.lin_rx_out(lin_rx), .trx_state(st));
	ltmc_bus_model bus (.core_clk(core_clk), .bus_level(bl),
		.bus_below_prewake(bp), .lin_rx_in(lri));
	//////////////////////////////////////////////////////////////
	// Compare and count; unknowns never match
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	// AXI write: address and data offered together, each released when taken
	task automatic wr(input logic [31:0] a, input logic [7:0] d);
		@(posedge core_clk);
		awa <= a;
		wd <= {24'h0, d};
		awv <= 1'b1;
		wv <= 1'b1;
		bre <= 1'b1;
		fork
			begin
				do @(posedge core_clk); while (!aw_rdy);
				awv <= 1'b0;
			end
			begin
				do @(posedge core_clk); while (!w_rdy);
				wv <= 1'b0;
			end
		join
		do @(posedge core_clk); while (!b_vld);
		bre <= 1'b0;
		last_bresp = b_rsp;
	endtask
	// AXI read, then compare the returned byte
	task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
		@(posedge core_clk);
		ara <= a;
		arv <= 1'b1;
		rre <= 1'b1;
		do @(posedge core_clk); while (!ar_rdy);
		arv <= 1'b0;
		do @(posedge core_clk); while (!r_vld);
		rre <= 1'b0;
		last_rsp = r_rsp;
		chk(r_dat, exp);
	endtask
	// State moves one edge after its cause; two edges leave margin
	task automatic st_chk(input ltmc_pkg::ltmc_state_t s);
		repeat (2) @(posedge core_clk);
		chk(st, s);
	endtask
	//////////////////////////////////////////////////////////////
	task automatic t_power;
		chk(st, ltmc_pkg::LTMC_UNPOWERED);
		rchk(CTRL, 32'h01);
		rchk(STAT, 32'h00);
		rchk(32'h200, 32'h00);
		chk(last_rsp, 2'b10);
		// Unmapped, out-of-range and lane-0-off writes leave control alone
		wr(32'h200, 8'h55);
		chk(last_bresp, 2'b10);
		wr(CTRL | 32'h400, 8'h02);
		chk(last_bresp, 2'b10);
		rchk(CTRL | 32'h400, 32'h00);
		chk(last_rsp, 2'b10);
		strb <= 4'he;
		wr(CTRL, 8'h02);
		chk(last_bresp, 2'b00);
		strb <= 4'hf;
		rchk(CTRL, 32'h01);
		sup.vs_pwron <= 1'b1;
		st_chk(ltmc_pkg::LTMC_STANDBY);
		wr(CTRL, 8'hff);
		chk(last_bresp, 2'b00);
		rchk(CTRL, 32'h03);
		wr(DEVM, 8'h04);
		st_chk(ltmc_pkg::LTMC_STANDBY);
		wr(CTRL, 8'h00);
		st_chk(ltmc_pkg::LTMC_STANDBY);
		$display("power-up test done");
	endtask
	task automatic t_normal;
		wr(CTRL, 8'h02);
		st_chk(ltmc_pkg::LTMC_NORMAL);
		rchk(STAT, 32'h01);
		rchk(CTRL, 32'h02);
		chk(phy.termination_on, 1'b1);
		chk(phy.tx_enable, 1'b1);
		// Dominant bus in Normal reaches the receive pin, never the wake path
		bus.set_level(1'b0);
		@(posedge core_clk);
		chk(lin_rx, 1'b0);
		chk(can_rx, 1'b1);
		chk(phy.wake_rx_on, 1'b0);
		bus.set_level(1'b1);
		@(posedge core_clk);
		chk(lin_rx, 1'b1);
		tx_to <= 1'b1;
		rchk(STAT, 32'h02);
		chk(phy.tx_enable, 1'b0);
		tx_to <= 1'b0;
		// Overtemp, VCC and VS undervoltage each drop to standby
		for (int i = 0; i < 3; i++) begin
			sup[i] <= 1'b1;
			st_chk(ltmc_pkg::LTMC_STANDBY);
			sup[i] <= 1'b0;
			st_chk(ltmc_pkg::LTMC_NORMAL);
		end
		for (int d = 1; d < 4; d++) begin
			wr(DEVM, 8'(d));
			st_chk(ltmc_pkg::LTMC_STANDBY);
			wr(DEVM, 8'h04);
			st_chk(ltmc_pkg::LTMC_NORMAL);
		end
		wr(CTRL, 8'h01);
		st_chk(ltmc_pkg::LTMC_STANDBY);
		$display("normal test done");
	endtask
	task automatic t_wake;
		wr(WAKE, 8'h01);
		chk(phy.termination_on, 1'b0);
		// Prewake level turns on receiver at once, pull-up one edge later
		bus.set_level(1'b0);
		@(posedge core_clk);
		chk(phy.wake_rx_on, 1'b1);
		@(posedge core_clk);
		chk(phy.strong_pullup, 1'b1);
		bus.set_level(1'b1);
		bus.pulse_dom(6);
		bus.pulse_dom(6);
		rchk(WAKE, 32'h01);
		bus.pulse_dom(12);
		chk(can_rx, 1'b0);
		chk(lin_rx, 1'b0);
		chk(phy.strong_pullup, 1'b1);
		rchk(WAKE, 32'h03);
		wr(WAKE, 8'h01);
		rchk(WAKE, 32'h01);
		chk(phy.strong_pullup, 1'b0);
		sup.overtemp <= 1'b1;
		bus.pulse_dom(12);
		rchk(WAKE, 32'h01);
		sup.overtemp <= 1'b0;
		sup.vs_uv <= 1'b1;
		bus.pulse_dom(12);
		rchk(WAKE, 32'h01);
		sup.vs_pwron <= 1'b0;
		sup.vs_pwroff <= 1'b1;
		st_chk(ltmc_pkg::LTMC_UNPOWERED);
		$display("wake test done");
	endtask
	//////////////////////////////////////////////////////////////
	task automatic close_out;
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Free-running 100 MHz clock
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	// Hang guard well above the expected run length
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			bad_count++;
			close_out;
		end
	end
	// Main sequence
	initial begin
		{rst, awv, wv, bre, arv, rre, tx_to} = 7'h40;
		{awa, wd, ara} = '0;
		sup = '0;
		strb = 4'hf;
		repeat (12) @(posedge core_clk);
		rst <= 1'b0;
		t_power;
		t_normal;
		t_wake;
		close_out;
	end
endmodule
bind ltmc_top ltmc_chk chk (.core_clk(core_clk), .rst(rst),
	.supply(supply), .bus_below_prewake(bus_below_prewake), .phy(phy),
	.trx_state(trx_state));
